// ### hdl/vsc_decoder.sv
// serial command decoder: frames in over the serial port, operations out
// to the array controller, and a small wishbone register slave.
// assumes serial pins are already synchronous to clk_i.
//
// Contract
// - 20-bit frame: 5-bit op, 15-bit parameter
// - op 00000 does nothing
// - op 00001 shifts identity on next frame
// - sector fast-forward loops within addressed sector
// - current fast-forward advances sector by sector
// - end marker halts fast-forward, asserts interrupt
// - outputs muted during any fast-forward
// - wake: bits 9-2 divider, 1-0 rate
// - rate codes select 6.4/4.0/8.0/5.3 kHz
// - divider N 1 to 256, not 2; code passes a divider of 2 through unchanged
// - stop ends operation; sleep also powers down
// - record at given or current sector
// - wipe erases addressed sector
// - store: address, pad, data bits, pad
// - fetch shifts stored bits first to last
// - play at given or current sector
// - sample on rising clock while select low
// - 640 sectors, low 10 address bits used
`timescale 1ns/1ns
`default_nettype none
module vsc_decoder
    import vsc_pkg::*;
#(
    parameter logic [4:0] FAMILY_CODE = 5'h15, // arbitrary value
    parameter logic [3:0] DEVICE_CODE = 4'h9   // arbitrary value
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // serial command port
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    output logic             int_n_o,
    output logic             busy_n_o,
    // array controller side
    input  wire logic        end_marker_i,   // end marker found
    input  wire logic        sector_end_i,   // reached end of sector
    input  wire logic        lbat_i,         // supply below spec
    input  wire logic        fetch_bit_i,    // bit at fetch_req_o
    output logic             fetch_req_o,
    output logic             store_valid_o,
    output logic             store_bit_o,
    output logic             wipe_o,
    output logic [SECT_BITS-1:0] sector_o,
    output logic [3:0]       state_o,
    output logic             mute_o,
    output logic             powered_o,
    output logic [8:0]       ext_div_o,
    output logic [1:0]       rate_sel_o,
    output logic [6:0]       rate_dkhz_o,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    ////////////////////////////////////////////////////////////////
    // serial front end
    logic                  sclk_q;      // last clock level
    logic [FRAME_BITS-1:0] shin_q;      // incoming frame
    logic [CNT_W-1:0]      cnt_q;       // bits taken this frame
    logic [FRAME_BITS-1:0] shout_q;     // outgoing status or id
    logic                  cs_q;        // last select level
    logic                  id_pend_q;   // next frame shows identity
    logic                  en_q;        // command port enable
    logic [4:0]            op_q;        // op code of frame in progress
    logic                  rise;
    logic                  fall;
    logic                  frame_start;
    logic                  frame_done;
    logic [OP_BITS-1:0]    op;
    logic [PARAM_BITS-1:0] prm;
    logic [FRAME_BITS-1:0] nxt_frame;
    vsc_state_t            st_q;
    logic [SECT_BITS-1:0]  sect_q;
    logic                  ovf_q;       // recorded past the array
    logic                  eod_q;       // halted by end marker
    logic                  ill_q;       // illegal address sent
    logic                  int_q;
    logic [7:0]            div_q;
    logic [1:0]            rate_q;
    logic                  pwr_q;
    logic                  ack_q;
    logic [31:0]           rd_d;
    logic                  ill_set;
    logic                  eod_set;
    logic                  ovf_set;

    // the clock level is sampled directly: inputs are synchronous
    assign rise        = spi_sclk_i & ~sclk_q & ~spi_cs_n_i;
    assign fall        = ~spi_sclk_i & sclk_q & ~spi_cs_n_i;
    assign frame_start = ~spi_cs_n_i & cs_q;
    assign nxt_frame   = {shin_q[FRAME_BITS-2:0], spi_mosi_i};
    // command acts on the twentieth bit
    assign frame_done  = rise & en_q & (cnt_q == CNT_W'(FRAME_BITS - 1));
    assign op          = nxt_frame[FRAME_BITS-1 -: OP_BITS];
    assign prm         = nxt_frame[PARAM_BITS-1:0];

    // edge history
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end
        else
        begin
            sclk_q <= spi_sclk_i;
            cs_q   <= spi_cs_n_i;
        end
    end

    // input shifter and bit counter, cleared whenever select is high
    always_ff @(posedge clk_i)
    begin
        if (rst_i || spi_cs_n_i)
        begin
            shin_q <= '0;
            cnt_q  <= '0;
            op_q   <= OP_NOP;
        end
        else if (rise)
        begin
            shin_q <= nxt_frame;
            if (cnt_q != '1)
                cnt_q <= cnt_q + CNT_W'(1);
            if (frame_done)
                op_q <= op;
        end
    end

    ////////////////////////////////////////////////////////////////
    // data phases of store and fetch frames
    logic in_data;
    logic [CNT_W-1:0] dbeg;
    assign dbeg    = CNT_W'(FRAME_BITS + PAD_BITS);
    assign in_data = (cnt_q >= dbeg) && (cnt_q < dbeg + CNT_W'(DATA_BITS));

    // store bits pass out as one-cycle strobes, pads are dropped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            store_valid_o <= 1'b0;
            store_bit_o   <= 1'b0;
        end
        else
        begin
            store_valid_o <= rise && op_q == OP_STORE && in_data;
            store_bit_o   <= spi_mosi_i;
        end
    end

    // fetch asks for the next bit on each of the first DATA_BITS falling edges after the command
    logic fetch_win;
    assign fetch_win   = (cnt_q >= CNT_W'(FRAME_BITS))
                      && (cnt_q < CNT_W'(FRAME_BITS + DATA_BITS));
    assign fetch_req_o = fall && op_q == OP_FETCH && fetch_win;

    // outgoing shifter: status, identity or fetched data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shout_q    <= '0;
            spi_miso_o <= 1'b0;
        end
        else if (frame_start)
        begin
            if (id_pend_q)
                shout_q <= {ovf_q, eod_q, ill_q, lbat_i,
                            FAMILY_CODE, DEVICE_CODE, 7'h00};
            else
                shout_q <= {ovf_q, eod_q, ill_q, lbat_i, 1'b0,
                            5'h00, sect_q};
            spi_miso_o <= ovf_q;
        end
        else if (fetch_req_o)
            spi_miso_o <= fetch_bit_i;
        else if (fall)
        begin
            shout_q    <= {shout_q[FRAME_BITS-2:0], 1'b0};
            spi_miso_o <= shout_q[FRAME_BITS-2];
        end
    end

    // identity request lasts for exactly the following frame
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            id_pend_q <= 1'b0;
        else if (frame_done)
            id_pend_q <= (op == OP_ID);
    end

    ////////////////////////////////////////////////////////////////
    // operation sequencer
    logic at_last;
    logic sect_ok;
    assign at_last = (sect_q == SECT_BITS'(SECTORS - 1));
    // only the low ten bits address a sector
    assign sect_ok = (prm[PARAM_BITS-1:SECT_BITS] == '0)
                  && (prm[SECT_BITS-1:0] < SECT_BITS'(SECTORS));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q   <= ST_SLEEP;
            sect_q <= '0;
            wipe_o <= 1'b0;
        end
        else
        begin
            wipe_o <= 1'b0;
            if (frame_done && st_q == ST_SLEEP)
            begin
                // asleep only a wake frame is honoured
                if (op == OP_WAKE)
                begin
                    st_q   <= ST_IDLE;
                    sect_q <= '0;
                end
            end
            else if (frame_done)
            begin
                case (op)
                    OP_FFS, OP_RECS, OP_PLAYS, OP_WIPE:
                    if (sect_ok)
                    begin
                        sect_q <= prm[SECT_BITS-1:0];
                        if (op == OP_FFS)
                            st_q <= ST_FFS;
                        else if (op == OP_RECS)
                            st_q <= ST_RECS;
                        else if (op == OP_PLAYS)
                            st_q <= ST_PLAYS;
                        else
                            wipe_o <= 1'b1;
                    end
                    OP_FFC:   st_q <= ST_FFC;
                    OP_RECC:  st_q <= ST_RECC;
                    OP_PLAYC: st_q <= ST_PLAYC;
                    OP_STORE, OP_FETCH:
                    if (sect_ok)
                        sect_q <= prm[SECT_BITS-1:0];
                    OP_WAKE:
                    begin
                        st_q   <= ST_IDLE;
                        sect_q <= '0;
                    end
                    OP_STOP:  st_q <= ST_IDLE;
                    OP_SLEEP: st_q <= ST_SLEEP;
                    // no-op, identity and unknown codes change nothing
                    default: ;
                endcase
            end
            else if (end_marker_i
                  && (st_q == ST_FFS || st_q == ST_FFC
                   || st_q == ST_PLAYS || st_q == ST_PLAYC))
                st_q <= ST_IDLE;
            else if (sector_end_i)
            begin
                case (st_q)
                    // single-sector modes restart in place
                    ST_FFS, ST_RECS, ST_PLAYS: ;
                    ST_FFC, ST_RECC, ST_PLAYC:
                    if (at_last)
                        st_q <= ST_IDLE;
                    else
                        sect_q <= sect_q + SECT_BITS'(1);
                    default: ;
                endcase
            end
        end
    end

    assign ill_set = frame_done && st_q != ST_SLEEP && !sect_ok
                  && (op == OP_FFS || op == OP_RECS || op == OP_PLAYS
                   || op == OP_WIPE || op == OP_STORE || op == OP_FETCH);
    assign eod_set = end_marker_i && (st_q == ST_FFS || st_q == ST_FFC
                   || st_q == ST_PLAYS || st_q == ST_PLAYC);
    assign ovf_set = sector_end_i && at_last && st_q == ST_RECC;

    // sticky flags: cleared by a status shift-out, a new event wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovf_q <= 1'b0;
            eod_q <= 1'b0;
            ill_q <= 1'b0;
        end
        else
        begin
            if (ovf_set)
                ovf_q <= 1'b1;
            else if (frame_start)
                ovf_q <= 1'b0;
            if (eod_set)
                eod_q <= 1'b1;
            else if (frame_start)
                eod_q <= 1'b0;
            if (ill_set)
                ill_q <= 1'b1;
            else if (frame_start && !id_pend_q)
                ill_q <= 1'b0;
        end
    end

    // interrupt holds low from an end marker during fast-forward, not playback, until the next command
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            int_q <= 1'b0;
        else if (eod_set && (st_q == ST_FFS || st_q == ST_FFC))
            int_q <= 1'b1;
        else if (frame_done)
            int_q <= 1'b0;
    end

    // divider and rate latch on a wake frame; upper bits must be zero, the code ignores them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_q  <= 8'h01;
            rate_q <= 2'h0;
            pwr_q  <= 1'b0;
        end
        else if (frame_done && op == OP_WAKE)
        begin
            // zero stands for 256; a code of 2 is the host's fault
            div_q  <= prm[9:2];
            rate_q <= prm[1:0];
            pwr_q  <= 1'b1;
        end
        else if (frame_done && op == OP_SLEEP && st_q != ST_SLEEP)
            pwr_q  <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // outputs toward the array
    assign sector_o   = sect_q;
    assign state_o    = st_q;
    assign int_n_o    = ~int_q;
    assign mute_o     = (st_q == ST_FFS) || (st_q == ST_FFC);
    assign powered_o  = pwr_q;
    assign busy_n_o   = ~(op_q == OP_STORE || op_q == OP_FETCH);
    assign ext_div_o  = (div_q == 8'h00) ? 9'h100 : {1'b0, div_q};
    assign rate_sel_o = rate_q;
    always_comb
    begin
        case (rate_q)
            2'h0:    rate_dkhz_o = RATE_00;
            2'h1:    rate_dkhz_o = RATE_01;
            2'h2:    rate_dkhz_o = RATE_10;
            default: rate_dkhz_o = RATE_11;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // wishbone slave: answer one cycle after the strobe, then drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end

    // control: bit 0 enables the command port
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            en_q <= CTRL_RST[0];
        else if (ack_q && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])
            en_q <= wb_dat_i[0];
    end

    // read mux, unmapped addresses read zero
    always_comb
    begin
        if (wb_adr_i == REG_CTRL)
            rd_d = {31'h0, en_q};
        else if (wb_adr_i == REG_STAT)
            rd_d = {12'h0, lbat_i, ill_q, eod_q, ovf_q, int_q, pwr_q,
                    st_q, sect_q};
        else if (wb_adr_i == REG_CONF)
            rd_d = {21'h0, rate_q, ext_div_o};
        else
            rd_d = 32'h0000_0000;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else
            wb_dat_o <= rd_d;
    end
    assign wb_ack_o = ack_q;
endmodule : vsc_decoder
`default_nettype wire

// ### hdl/vsc_pkg.sv
// constants for the serial command decoder of the voice store
// assumes one 250 MHz system clock
package vsc_pkg;
    localparam int FRAME_BITS  = 20;         // op code plus parameter
    localparam int OP_BITS     = 5;
    localparam int PARAM_BITS  = 15;
    localparam int SECT_BITS   = 10;         // meaningful address bits
    localparam int SECTORS     = 640;
    localparam int DATA_BITS   = 3004;       // bits in one data sector
    localparam int PAD_BITS    = 4;          // don't-care bits around data
    localparam int CNT_W       = 12;
    // op codes
    localparam logic [4:0] OP_NOP   = 5'h00;
    localparam logic [4:0] OP_ID    = 5'h01;
    localparam logic [4:0] OP_FFS   = 5'h02; // skip_ahead_at_sector
    localparam logic [4:0] OP_FFC   = 5'h03; // skip_ahead_current
    localparam logic [4:0] OP_WAKE  = 5'h04; // wake_and_configure
    localparam logic [4:0] OP_STOP  = 5'h06;
    localparam logic [4:0] OP_SLEEP = 5'h07; // halt_and_sleep
    localparam logic [4:0] OP_RECS  = 5'h08; // capture_audio_at_sector
    localparam logic [4:0] OP_RECC  = 5'h09; // capture_audio_current
    localparam logic [4:0] OP_WIPE  = 5'h0A; // sector_wipe
    localparam logic [4:0] OP_STORE = 5'h0B; // sector_data_store
    localparam logic [4:0] OP_PLAYS = 5'h0C;
    localparam logic [4:0] OP_PLAYC = 5'h0D;
    localparam logic [4:0] OP_FETCH = 5'h0F; // sector_data_fetch
    // wishbone register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_CONF = 4'h8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // sample rate per select code, in units of 0.1 kHz
    localparam logic [6:0] RATE_00 = 7'h40;  // 6.4 kHz
    localparam logic [6:0] RATE_01 = 7'h28;  // 4.0 kHz
    localparam logic [6:0] RATE_10 = 7'h50;  // 8.0 kHz
    localparam logic [6:0] RATE_11 = 7'h35;  // 5.3 kHz
    typedef enum logic [3:0] {
        ST_IDLE, ST_FFS, ST_FFC, ST_RECS, ST_RECC, ST_PLAYS, ST_PLAYC, ST_SLEEP
    } vsc_state_t;
endpackage : vsc_pkg

// ### bench/vsc_decoder_asserts.sv
// concurrent checks on the ports of the serial command decoder
// assumes the decoder's single clock and synchronous reset
`timescale 1ns/1ns
`default_nettype none
module vsc_decoder_asserts
    import vsc_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // array events and decoder outputs
    input  wire logic                 end_marker_i,
    input  wire logic                 sector_end_i,
    input  wire logic                 fetch_req_o,
    input  wire logic                 store_valid_o,
    input  wire logic                 busy_n_o,
    input  wire logic                 int_n_o,
    input  wire logic                 mute_o,
    input  wire logic                 powered_o,
    input  wire logic [SECT_BITS-1:0] sector_o,
    input  wire logic [3:0]           state_o,
    input  wire logic [8:0]           ext_div_o,
    input  wire logic [1:0]           rate_sel_o,
    input  wire logic [6:0]           rate_dkhz_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // array events seen while skipping ahead
    sequence eod_in_skip;
        end_marker_i && (state_o == 4'h1 || state_o == 4'h2);
    endsequence
    sequence wrap_in_ffs;
        sector_end_i && state_o == 4'h1;
    endsequence
    // last sector is left out: there the sweep ends instead
    sequence step_in_ffc;
        sector_end_i && state_o == 4'h2 && sector_o < 10'h27F;
    endsequence
    ////////////////////////////////////////////////////////////////
    skip_stop_a: assert property (eod_in_skip |=> state_o == 4'h0 && !int_n_o)
        else $error("end marker did not stop the skip");
    ffs_loop_a: assert property (wrap_in_ffs |=> state_o == 4'h1 && $stable(sector_o))
        else $error("sector skip left its sector");
    ffc_step_a: assert property (step_in_ffc |=> sector_o == $past(sector_o) + 10'h001)
        else $error("current skip did not advance");
    mute_skip_a: assert property (mute_o == (state_o == 4'h1 || state_o == 4'h2))
        else $error("mute does not follow skip state");
    rate_map_a: assert property (rate_dkhz_o == (rate_sel_o == 2'h0 ? RATE_00 :
        rate_sel_o == 2'h1 ? RATE_01 : rate_sel_o == 2'h2 ? RATE_10 : RATE_11))
        else $error("rate does not match select code");
    div_range_a: assert property (ext_div_o != 9'h000 && ext_div_o <= 9'h100)
        else $error("divider out of range");
    sect_range_a: assert property (sector_o < 10'h280)
        else $error("sector beyond the array");
    sleep_off_a: assert property (state_o == 4'h7 |-> !powered_o)
        else $error("powered while asleep");
    data_busy_a: assert property ((fetch_req_o || store_valid_o) |-> !busy_n_o)
        else $error("data moved while not busy");
endmodule : vsc_decoder_asserts

bind vsc_decoder vsc_decoder_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .end_marker_i(end_marker_i), .sector_end_i(sector_end_i), .fetch_req_o(fetch_req_o),
    .store_valid_o(store_valid_o), .busy_n_o(busy_n_o), .int_n_o(int_n_o), .mute_o(mute_o),
    .powered_o(powered_o), .sector_o(sector_o), .state_o(state_o), .ext_div_o(ext_div_o),
    .rate_sel_o(rate_sel_o), .rate_dkhz_o(rate_dkhz_o));
`default_nettype wire

// ### bench/vsc_host.sv
// host model: serial port master that sends command frames
// assumes the decoder samples the serial pins on clk_i
`timescale 1ns/1ns
`default_nettype none
module vsc_host (
    // clock and returned data
    input  wire logic clk_i,
    input  wire logic miso_i,
    // serial pins
    output var logic  sclk_o,
    output var logic  cs_n_o,
    output var logic  mosi_o
);
    logic [19:0] rx_q; // first 20 bits seen, bit 0 in rx_q[19]
    // clock idles low, select high
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // data pattern for bits past the command
    function automatic logic pat(input int i);
        return i[0] ^ i[2];
    endfunction : pat
    // one frame: command MSB first, then extra pattern bits
    task automatic xfer(input logic [19:0] cmd, input int extra);
        int k;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (k = 0; k < 20 + extra; k++)
        begin
            @(posedge clk_i);
            mosi_o <= (k < 20) ? cmd[19-k] : pat(k - 24);
            sclk_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            if (k < 20) rx_q[19-k] = miso_i;
            sclk_o <= 1'b1;
            @(posedge clk_i);
        end
        @(posedge clk_i);
        sclk_o <= 1'b0; // clock parks low so the next frame starts clean
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o; // released line must not keep its last value
        repeat (4) @(posedge clk_i);
    endtask : xfer
endmodule : vsc_host
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the serial command decoder
// assumes the host model drives the serial pins
`timescale 1ns/1ns
`default_nettype none
module tb;
    import vsc_pkg::*;
    localparam logic [4:0] FAM = 5'h13; // arbitrary value
    localparam logic [3:0] DEV = 4'hC;  // arbitrary value
    logic        clk_i, rst_i, sclk, cs_n, mosi, miso, int_n, busy_n;
    logic        end_marker, sec_end, lbat, fbit, freq, sval, sbit, wipe, mute, pwr;
    logic [9:0]  sector;
    logic [3:0]  state, adr;
    logic [8:0]  div;
    logic [1:0]  rsel;
    logic [6:0]  dkhz;
    logic        cyc, stb, we, ack;
    logic [31:0] wdat, rdat, q;
    int          failures = 0, n_tests = 0, n_wipe = 0, n_fetch = 0, n_store = 0, serr = 0;
    ////////////////////////////////////////////////////////////////
    vsc_decoder #(.FAMILY_CODE(FAM), .DEVICE_CODE(DEV)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .int_n_o(int_n), .busy_n_o(busy_n), .end_marker_i(end_marker), .sector_end_i(sec_end),
        .lbat_i(lbat), .fetch_bit_i(fbit), .fetch_req_o(freq), .store_valid_o(sval),
        .store_bit_o(sbit), .wipe_o(wipe), .sector_o(sector), .state_o(state), .mute_o(mute),
        .powered_o(pwr), .ext_div_o(div), .rate_sel_o(rsel), .rate_dkhz_o(dkhz),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    vsc_host u_host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    assign fbit = n_fetch[0]; // toggles with each fetch
    // counts data traffic
    always @(posedge clk_i)
    begin
        if (wipe) n_wipe <= n_wipe + 1;
        if (freq) n_fetch <= n_fetch + 1;
        if (sval && sbit !== u_host.pat(n_store)) serr <= serr + 1;
        if (sval) n_store <= n_store + 1;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // classic single wishbone cycle, waits for ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic step(input logic [4:0] op, input logic [14:0] p, input logic [3:0] st,
                        input logic [9:0] sc);
        u_host.xfer({op, p}, 0);
        chk("state", st, state);
        chk("sector", sc, sector);
    endtask : step
    task automatic pulse(input bit m);
        @(posedge clk_i);
        {end_marker, sec_end} <= {m, !m};
        @(posedge clk_i);
        {end_marker, sec_end} <= 2'b00;
        @(posedge clk_i);
    endtask : pulse
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("state", 4'h7, state);
        chk("sector", 0, sector);
        chk("div", 1, div);
        chk("int", 1, int_n);
        wb(1'b0, REG_CTRL, 0);
        chk("ctrl", CTRL_RST, q);
        $display("test reset done");
    endtask : t_reset
    task automatic t_wake;
        logic [6:0] dk [4] = '{RATE_00, RATE_01, RATE_10, RATE_11};
        step(OP_FFS, 15'h0005, 4'h7, 10'h000);
        for (int r = 0; r < 4; r++)
        begin
            u_host.xfer({OP_WAKE, 5'h00, 8'(r + 7), 2'(r)}, 0);
            chk("rate", r, rsel);
            chk("khz", dk[r], dkhz);
            chk("div", r + 7, div);
        end
        step(OP_WAKE, 15'h0002, 4'h0, 10'h000);
        chk("div", 256, div);
        chk("powered", 1, pwr);
        $display("test wake done");
    endtask : t_wake
    task automatic t_skip;
        step(OP_FFS, 15'h0005, 4'h1, 10'h005);
        chk("mute", 1, mute);
        pulse(1'b0);
        chk("sector", 5, sector);
        step(OP_FFC, 15'h0000, 4'h2, 10'h005);
        pulse(1'b0);
        chk("sector", 6, sector);
        pulse(1'b1);
        chk("state", 0, state);
        chk("int", 0, int_n);
        chk("mute", 0, mute);
        step(OP_NOP, 15'h7FFF, 4'h0, 10'h006);
        chk("eod", 1, u_host.rx_q[18]);
        chk("int", 1, int_n);
        $display("test skip done");
    endtask : t_skip
    task automatic t_rec_play;
        step(OP_RECS, 15'h000C, 4'h3, 10'h00C);
        step(OP_RECC, 15'h0000, 4'h4, 10'h00C);
        step(OP_NOP, 15'h0000, 4'h4, 10'h00C);
        step(OP_STOP, 15'h0000, 4'h0, 10'h00C);
        step(OP_PLAYS, 15'h0014, 4'h5, 10'h014);
        step(OP_PLAYC, 15'h0000, 4'h6, 10'h014);
        step(OP_STOP, 15'h0000, 4'h0, 10'h014);
        $display("test record play done");
    endtask : t_rec_play
    task automatic t_odd;
        @(posedge clk_i);
        lbat <= 1'b1;
        step(OP_RECS, 15'h0280, 4'h0, 10'h014);
        step(5'h05, 15'h0003, 4'h0, 10'h014);
        chk("illegal", 1, u_host.rx_q[17]);
        step(5'h1F, 15'h0009, 4'h0, 10'h014);
        step(OP_ID, 15'h0000, 4'h0, 10'h014);
        u_host.xfer({OP_NOP, 15'h0000}, 0);
        chk("family", FAM, u_host.rx_q[15:11]);
        chk("device", DEV, u_host.rx_q[10:7]);
        chk("lbat", 1, u_host.rx_q[16]);
        lbat <= 1'b0;
        $display("test odd codes done");
    endtask : t_odd
    task automatic t_data;
        u_host.xfer({OP_WIPE, 15'h0003}, 0);
        chk("wipes", 1, n_wipe);
        u_host.xfer({OP_STORE, 15'h0003}, 3012);
        chk("stored", 3004, n_store);
        chk("store bits", 0, serr);
        chk("sector", 3, sector);
        u_host.xfer({OP_FETCH, 15'h0004}, 3004);
        chk("fetched", 3004, n_fetch);
        chk("busy", 1, busy_n);
        $display("test data done");
    endtask : t_data
    task automatic t_ctrl;
        wb(1'b1, REG_CTRL, 0);
        step(OP_PLAYS, 15'h001E, 4'h0, 10'h004);
        wb(1'b1, REG_CTRL, 1);
        wb(1'b0, REG_CONF, 0);
        chk("conf", 32'h0000_0500, q);
        wb(1'b0, REG_STAT, 0);
        chk("stat", 15'h4004, q[14:0]);
        step(OP_SLEEP, 15'h0000, 4'h7, 10'h004);
        chk("powered", 0, pwr);
        step(OP_RECS, 15'h0001, 4'h7, 10'h004);
        wb(1'b1, 4'hC, 32'hFFFF_FFFF);
        wb(1'b0, 4'hC, 0);
        chk("unmapped", 0, q);
        $display("test control done");
    endtask : t_ctrl
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_i, end_marker, sec_end, lbat, cyc, stb, we, adr, wdat} = '0;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_wake();
        t_skip();
        t_rec_play();
        t_odd();
        t_data();
        t_ctrl();
        tally_and_finish();
    end
    // watchdog: about twice the expected run
    initial
    begin
        repeat (60000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
